// ==== verilog/asp_core.sv ====
// Asynchronous serial port core with APB registers
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "asp_regs.svh"
module asp_core
  import asp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial line
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  // Interrupt
  output logic irq
);
  localparam logic [4:0] MIN_DIV = 5'(`ASP_MIN_DIV);

  // Register state
  logic [7:0] line_mode_control, mode_next;
  logic [4:0] baud_divider_control, baud_next;
  logic [7:0] receive_buffer_reg, rxbuf_next;
  logic [2:0] rx_error_status, err_next;
  logic [2:0] irq_stat_reg, irq_stat_next;
  logic [2:0] irq_mask_reg, irq_mask_next;
  logic rx_full_reg, rx_full_next;
  logic wr, rd, power, tx_en_sw, rx_en_sw;
  logic [1:0] par_sel;
  logic char8, stop2;
  // Pin synchroniser
  logic rx_meta_reg, rx_sync_reg;
  // Baud divider
  logic [4:0] div_reg, div_next;
  logic base_tick;
  // Enable synchronisers on base clock
  logic [1:0] txe_sync_reg, txe_sync_next, rxe_sync_reg, rxe_sync_next;
  logic tx_en, rx_en;
  // Transmitter
  asp_tx_state_t tx_state_reg, tx_state_next;
  logic [7:0] transmit_shift_reg, txs_next;
  logic [3:0] tx_os_reg, tx_os_next;
  logic [2:0] tx_bit_reg, tx_bit_next;
  logic tx_par_reg, tx_par_next, tx_stop2_reg, tx_stop2_next;
  logic tx_busy_reg, tx_busy_next, tx_out_next, tx_done;
  logic bit_end;
  // Receiver outputs
  logic rx_done, rx_pe, rx_fe;
  logic [7:0] rx_data;
  logic rx_line;

  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign power = line_mode_control[`ASP_MODE_POWER];
  assign tx_en_sw = line_mode_control[`ASP_MODE_TXE];
  assign rx_en_sw = line_mode_control[`ASP_MODE_RXE];
  assign par_sel = line_mode_control[`ASP_MODE_PAR_HI:`ASP_MODE_PAR_LO];
  assign char8 = line_mode_control[`ASP_MODE_CL];
  assign stop2 = line_mode_control[`ASP_MODE_SL];
  assign irq = |(irq_stat_reg & irq_mask_reg);

  // Input pin synchroniser
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
    end else begin
      rx_meta_reg <= serial_in_pin;
      rx_sync_reg <= rx_meta_reg;
    end
  end

  assign rx_line = power ? rx_sync_reg : 1'b1;

  // Baud divider and enable synchronisers
  always_comb begin
    // Five-bit divider, floored for max rate
    div_next = div_reg + 5'h1;
    base_tick = 1'b0;
    if (div_reg >= ((baud_divider_control < MIN_DIV) ? MIN_DIV : baud_divider_control) - 5'h1) begin
      div_next = 5'h0;
      base_tick = 1'b1;
    end
    if (!power) begin
      div_next = 5'h0;
      base_tick = 1'b0;
    end
    txe_sync_next = base_tick ? {txe_sync_reg[0], tx_en_sw} : txe_sync_reg;
    rxe_sync_next = base_tick ? {rxe_sync_reg[0], rx_en_sw} : rxe_sync_reg;
    if (!power) begin
      txe_sync_next = 2'b00;
      rxe_sync_next = 2'b00;
    end
  end

  // All state only moves on clk edges
  always_ff @(posedge clk) begin
    if (!resetn) begin
      div_reg <= 5'h0;
      txe_sync_reg <= 2'b00;
      rxe_sync_reg <= 2'b00;
    end else begin
      div_reg <= div_next;
      txe_sync_reg <= txe_sync_next;
      rxe_sync_reg <= rxe_sync_next;
    end
  end

  assign tx_en = txe_sync_reg[1] && tx_en_sw;
  assign rx_en = rxe_sync_reg[1] && rx_en_sw;

  asp_rx u_rx (
    .clk(clk),
    .resetn(resetn),
    .enable(rx_en),
    .base_tick(base_tick),
    .par_sel(par_sel),
    .char8(char8),
    .line_in(rx_line),
    .done(rx_done),
    .data(rx_data),
    .par_err(rx_pe),
    .frame_err(rx_fe)
  );

  // Transmitter next state
  assign bit_end = base_tick && (tx_os_reg == 4'hf);
  always_comb begin
    tx_state_next = tx_state_reg;
    txs_next = transmit_shift_reg;
    tx_os_next = base_tick ? tx_os_reg + 4'h1 : tx_os_reg;
    tx_bit_next = tx_bit_reg;
    tx_par_next = tx_par_reg;
    tx_stop2_next = tx_stop2_reg;
    tx_busy_next = tx_busy_reg;
    tx_out_next = serial_out_pin;
    tx_done = 1'b0;
    unique case (tx_state_reg)
      ASP_TX_IDLE: begin
        tx_out_next = 1'b1;
        tx_os_next = 4'h0;
        if (tx_busy_reg && base_tick) begin
          tx_state_next = ASP_TX_START;
          tx_out_next = 1'b0;
          tx_bit_next = 3'h0;
          tx_par_next = 1'b0;
        end
      end
      ASP_TX_START: begin
        if (bit_end) begin
          tx_state_next = ASP_TX_DATA;
          tx_out_next = transmit_shift_reg[0];
          tx_par_next = transmit_shift_reg[0];
          txs_next = {1'b1, transmit_shift_reg[7:1]};
        end
      end
      ASP_TX_DATA: begin
        if (bit_end) begin
          tx_bit_next = tx_bit_reg + 3'h1;
          if (tx_bit_reg == (char8 ? 3'h7 : 3'h6)) begin
            tx_state_next = (par_sel == 2'b00) ? ASP_TX_STOP : ASP_TX_PAR;
            tx_out_next = (par_sel == 2'b00) ? 1'b1 : (par_sel == 2'b01) ? 1'b0 :
                          (par_sel == 2'b10) ? !tx_par_reg : tx_par_reg;
            tx_stop2_next = stop2;
          end else begin
            tx_out_next = transmit_shift_reg[0];
            tx_par_next = tx_par_reg ^ transmit_shift_reg[0];
            txs_next = {1'b1, transmit_shift_reg[7:1]};
          end
        end
      end
      ASP_TX_PAR: begin
        if (bit_end) begin
          tx_state_next = ASP_TX_STOP;
          tx_out_next = 1'b1;
        end
      end
      ASP_TX_STOP: begin
        if (bit_end) begin
          if (tx_stop2_reg) begin
            tx_stop2_next = 1'b0;
          end else begin
            tx_state_next = ASP_TX_IDLE;
            tx_busy_next = 1'b0;
            tx_done = 1'b1;
          end
        end
      end
    endcase
    // Load accepted only once enable is synchronised
    if (wr && paddr == `ASP_OFF_TXDATA && tx_en && !tx_busy_reg) begin
      txs_next = pwdata[7:0];
      tx_busy_next = 1'b1;
    end
    if (!tx_en) begin
      tx_state_next = ASP_TX_IDLE;
      txs_next = `ASP_BUF_RST;
      tx_busy_next = 1'b0;
      tx_out_next = 1'b1;
      tx_done = 1'b0;
    end
  end

  // Transmitter registers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tx_state_reg <= ASP_TX_IDLE;
      transmit_shift_reg <= `ASP_BUF_RST;
      tx_os_reg <= 4'h0;
      tx_bit_reg <= 3'h0;
      tx_par_reg <= 1'b0;
      tx_stop2_reg <= 1'b0;
      tx_busy_reg <= 1'b0;
      serial_out_pin <= 1'b1;
    end else begin
      tx_state_reg <= tx_state_next;
      transmit_shift_reg <= txs_next;
      tx_os_reg <= tx_os_next;
      tx_bit_reg <= tx_bit_next;
      tx_par_reg <= tx_par_next;
      tx_stop2_reg <= tx_stop2_next;
      tx_busy_reg <= tx_busy_next;
      serial_out_pin <= tx_out_next;
    end
  end

  // Software registers next values
  always_comb begin
    mode_next = line_mode_control;
    baud_next = baud_divider_control;
    rxbuf_next = receive_buffer_reg;
    err_next = rx_error_status;
    rx_full_next = rx_full_reg;
    irq_mask_next = irq_mask_reg;
    irq_stat_next = irq_stat_reg;
    if (wr && paddr == `ASP_OFF_MODE) begin
      mode_next = {pwdata[7:1], 1'b1};
    end
    if (wr && paddr == `ASP_OFF_BAUD) begin
      baud_next = pwdata[4:0];
    end
    if (wr && paddr == `ASP_OFF_IRQ_MASK) begin
      irq_mask_next = pwdata[2:0];
    end
    if (wr && paddr == `ASP_OFF_IRQ_STAT) begin
      irq_stat_next = irq_stat_reg & ~pwdata[2:0];
    end
    // Reading the status clears errors; reading the buffer only empties it
    if (rd && paddr == `ASP_OFF_STATUS) begin
      err_next = 3'h0;
    end
    if (rd && paddr == `ASP_OFF_RXDATA) begin
      rx_full_next = 1'b0;
    end
    if (rx_done) begin
      if (rx_full_reg && !(rd && paddr == `ASP_OFF_RXDATA)) begin
        err_next[`ASP_ST_OVE] = 1'b1;
      end else begin
        rxbuf_next = rx_data;
        rx_full_next = 1'b1;
      end
      err_next[`ASP_ST_PE] = err_next[`ASP_ST_PE] | rx_pe;
      err_next[`ASP_ST_FE] = err_next[`ASP_ST_FE] | rx_fe;
    end
    // Events set wins over clear
    irq_stat_next[`ASP_IRQ_TXDONE] = irq_stat_next[`ASP_IRQ_TXDONE] | tx_done;
    irq_stat_next[`ASP_IRQ_RXDONE] = irq_stat_next[`ASP_IRQ_RXDONE] | rx_done;
    irq_stat_next[`ASP_IRQ_RXERR] = irq_stat_next[`ASP_IRQ_RXERR] | (rx_done && (rx_pe || rx_fe ||
                                    (rx_full_reg && !(rd && paddr == `ASP_OFF_RXDATA))));
    if (!mode_next[`ASP_MODE_POWER]) begin
      rxbuf_next = `ASP_BUF_RST;
      err_next = 3'h0;
      rx_full_next = 1'b0;
    end else if (!mode_next[`ASP_MODE_RXE]) begin
      err_next = 3'h0;
    end
  end

  // Software registers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      line_mode_control <= `ASP_MODE_RST;
      baud_divider_control <= `ASP_BAUD_RST;
      receive_buffer_reg <= `ASP_BUF_RST;
      rx_error_status <= 3'h0;
      rx_full_reg <= 1'b0;
      irq_stat_reg <= 3'h0;
      irq_mask_reg <= 3'h0;
    end else begin
      line_mode_control <= mode_next;
      baud_divider_control <= baud_next;
      receive_buffer_reg <= rxbuf_next;
      rx_error_status <= err_next;
      rx_full_reg <= rx_full_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
    end
  end

  always_comb begin
    prdata = 32'h0;
    unique case (paddr)
      `ASP_OFF_MODE: prdata = {24'h0, line_mode_control};
      `ASP_OFF_STATUS: prdata = {29'h0, rx_error_status};
      `ASP_OFF_BAUD: prdata = {27'h0, baud_divider_control};
      `ASP_OFF_RXDATA: prdata = {24'h0, receive_buffer_reg};
      `ASP_OFF_IRQ_STAT: prdata = {29'h0, irq_stat_reg};
      `ASP_OFF_IRQ_MASK: prdata = {29'h0, irq_mask_reg};
      default: prdata = 32'h0;
    endcase
  end

  chk_power_idle: assert property (@(posedge clk) disable iff (!resetn)
    !power |=> serial_out_pin) else $error("line not idle while unpowered");
  // Base ticks at least 4 clocks apart
  chk_div_floor: assert property (@(posedge clk) disable iff (!resetn)
    base_tick |=> !base_tick[*3]) else $error("base tick too fast");
  chk_txe_sync: assert property (@(posedge clk) disable iff (!resetn)
    $rose(tx_en) |-> $past(txe_sync_reg[0])) else $error("enable not synchronised");
  chk_start_low: assert property (@(posedge clk) disable iff (!resetn)
    (tx_state_reg == ASP_TX_IDLE && tx_state_next == ASP_TX_START && tx_en) |=> !serial_out_pin)
    else $error("start bit not low");
  chk_overrun_keep: assert property (@(posedge clk) disable iff (!resetn)
    (rx_done && rx_full_reg && paddr != `ASP_OFF_RXDATA && power) |=>
    (receive_buffer_reg == $past(receive_buffer_reg)) && rx_error_status[`ASP_ST_OVE])
    else $error("overrun overwrote buffer");
  chk_power_reset: assert property (@(posedge clk) disable iff (!resetn)
    !power |-> (receive_buffer_reg == `ASP_BUF_RST) && !tx_en && rx_error_status == 3'h0)
    else $error("unpowered state not reset");
  chk_lsb_first: assert property (@(posedge clk) disable iff (!resetn)
    (tx_state_reg == ASP_TX_START && bit_end && tx_en) |=> serial_out_pin == $past(transmit_shift_reg[0]))
    else $error("first data bit not lsb");
  chk_irq_level: assert property (@(posedge clk) disable iff (!resetn)
    irq == |(irq_stat_reg & irq_mask_reg)) else $error("irq mismatch");
  cov_tx_done: cover property (@(posedge clk) tx_done);
  cov_rx_done: cover property (@(posedge clk) rx_done && !rx_pe && !rx_fe);
  cov_overrun: cover property (@(posedge clk) rx_done && rx_full_reg);
endmodule : asp_core

// ==== verilog/asp_regs.svh ====
// Register offsets, field positions, reset values and timing counts of the serial port
`ifndef ASP_REGS_SVH
`define ASP_REGS_SVH

`define ASP_OFF_MODE 12'h000
`define ASP_OFF_STATUS 12'h004
`define ASP_OFF_BAUD 12'h008
`define ASP_OFF_TXDATA 12'h00c
`define ASP_OFF_RXDATA 12'h010
`define ASP_OFF_IRQ_STAT 12'h014
`define ASP_OFF_IRQ_MASK 12'h018

`define ASP_MODE_POWER 7
`define ASP_MODE_TXE 6
`define ASP_MODE_RXE 5
`define ASP_MODE_PAR_HI 4
`define ASP_MODE_PAR_LO 3
`define ASP_MODE_CL 2
`define ASP_MODE_SL 1
`define ASP_MODE_RST 8'h01

`define ASP_ST_PE 2
`define ASP_ST_FE 1
`define ASP_ST_OVE 0

`define ASP_IRQ_TXDONE 0
`define ASP_IRQ_RXDONE 1
`define ASP_IRQ_RXERR 2

`define ASP_BAUD_RST 5'h10
`define ASP_BUF_RST 8'hff
`define ASP_CLK_HZ 10000000
`define ASP_MAX_BPS 625000
`define ASP_MIN_DIV ((`ASP_CLK_HZ / `ASP_MAX_BPS))

`endif

// ==== verilog/asp_pkg.sv ====
// Types shared by the serial port files
package asp_pkg;
  typedef enum logic [1:0] {
    ASP_PAR_NONE,
    ASP_PAR_ZERO,
    ASP_PAR_ODD,
    ASP_PAR_EVEN
  } asp_par_t;
  typedef enum {
    ASP_TX_IDLE,
    ASP_TX_START,
    ASP_TX_DATA,
    ASP_TX_PAR,
    ASP_TX_STOP
  } asp_tx_state_t;
endpackage : asp_pkg

// ==== verilog/asp_rx.sv ====
// Receiver: sampling state machine and receive shift register
`timescale 1ns/10ps
`include "asp_regs.svh"
module asp_rx
  import asp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Control
  input wire logic enable,
  input wire logic base_tick,
  input wire logic [1:0] par_sel,
  input wire logic char8,
  input wire logic line_in,
  // Result
  output logic done,
  output logic [7:0] data,
  output logic par_err,
  output logic frame_err
);
  typedef enum {ASP_RX_IDLE, ASP_RX_START, ASP_RX_DATA, ASP_RX_PAR, ASP_RX_STOP} asp_rx_state_t;
  asp_rx_state_t state_reg, state_next;
  logic [3:0] os_reg, os_next;
  logic [2:0] bit_reg, bit_next;
  logic [7:0] shift_reg, shift_next;
  logic par_reg, par_next;
  logic done_next, pe_next, fe_next;
  logic [7:0] data_next;
  logic mid;

  // Oversampling: 16 base ticks per bit, sample at mid-bit
  assign mid = base_tick && (os_reg == 4'h7);

  // Next-state logic
  always_comb begin
    state_next = state_reg;
    os_next = base_tick ? os_reg + 4'h1 : os_reg;
    bit_next = bit_reg;
    shift_next = shift_reg;
    par_next = par_reg;
    done_next = 1'b0;
    data_next = data;
    pe_next = par_err;
    fe_next = frame_err;
    if (!enable) begin
      state_next = ASP_RX_IDLE;
      os_next = 4'h0;
    end else begin
      unique case (state_reg)
        ASP_RX_IDLE: begin
          os_next = 4'h0;
          if (!line_in) begin
            state_next = ASP_RX_START;
          end
        end
        ASP_RX_START: begin
          if (mid) begin
            os_next = 4'h8;
            state_next = line_in ? ASP_RX_IDLE : ASP_RX_DATA;
            bit_next = 3'h0;
            par_next = 1'b0;
          end
        end
        ASP_RX_DATA: begin
          if (mid) begin
            shift_next = {line_in, shift_reg[7:1]};
            par_next = par_reg ^ line_in;
            bit_next = bit_reg + 3'h1;
            if (bit_reg == (char8 ? 3'h7 : 3'h6)) begin
              state_next = (par_sel == 2'b00) ? ASP_RX_STOP : ASP_RX_PAR;
            end
          end
        end
        ASP_RX_PAR: begin
          if (mid) begin
            par_next = par_reg ^ line_in;
            state_next = ASP_RX_STOP;
          end
        end
        ASP_RX_STOP: begin
          if (mid) begin
            state_next = ASP_RX_IDLE;
            done_next = 1'b1;
            data_next = char8 ? shift_reg : {1'b0, shift_reg[7:1]};
            fe_next = !line_in;
            pe_next = (par_sel == 2'b10) ? !par_reg : (par_sel == 2'b11) ? par_reg : 1'b0;
          end
        end
      endcase
    end
  end

  // State registers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_reg <= ASP_RX_IDLE;
      os_reg <= 4'h0;
      bit_reg <= 3'h0;
      shift_reg <= `ASP_BUF_RST;
      par_reg <= 1'b0;
      done <= 1'b0;
      data <= `ASP_BUF_RST;
      par_err <= 1'b0;
      frame_err <= 1'b0;
    end else begin
      state_reg <= state_next;
      os_reg <= os_next;
      bit_reg <= bit_next;
      shift_reg <= shift_next;
      par_reg <= par_next;
      done <= done_next;
      data <= data_next;
      par_err <= pe_next;
      frame_err <= fe_next;
    end
  end
endmodule : asp_rx

// ==== verification/asp_peer_model.sv ====
// Remote serial peer: sends commanded frames, captures frames from the port
`timescale 1ns/10ps
module asp_peer_model #(
  parameter int BIT_CLK = 256
) (
  // Clock
  input wire logic clk,
  // Line
  input wire logic line_in,
  output logic line_out,
  // Send command
  input wire logic send,
  input wire logic [7:0] send_byte,
  input wire logic char8,
  input wire logic [1:0] par_mode,
  input wire logic bad_par,
  input wire logic bad_stop,
  // Captured frames
  output logic [11:0] rx_frame,
  output logic [7:0] rx_count,
  output logic busy
);
  logic [11:0] frame;
  logic [11:0] cap;
  logic [7:0] d;
  int n;
  int k;
  int j;

  // Idle line is high
  initial begin
    line_out = 1'b1;
    rx_frame = '1;
    rx_count = 8'h00;
    busy = 1'b0;
  end

  // start, data first bit lowest, parity, stop
  always begin
    @(posedge clk);
    if (send) begin
      frame = '1;
      frame[0] = 1'b0;
      d = char8 ? send_byte : {1'b0, send_byte[6:0]};
      n = char8 ? 8 : 7;
      for (k = 0; k < n; k++) frame[1 + k] = d[k];
      if (par_mode != 2'd0) begin
        frame[1 + n] = ((par_mode == 2'd2) ? ~^d : (par_mode == 2'd3) ? ^d : 1'b0) ^ bad_par;
        n++;
      end
      frame[1 + n] = ~bad_stop;
      busy <= 1'b1;
      for (k = 0; k < n + 2; k++) begin
        line_out <= frame[k];
        repeat (BIT_CLK) @(posedge clk);
      end
      line_out <= 1'b1;
      busy <= 1'b0;
    end
  end

  always begin
    @(negedge line_in);
    repeat (BIT_CLK / 2) @(posedge clk);
    for (j = 0; j < 12; j++) begin
      cap[j] = line_in;
      if (j < 11) repeat (BIT_CLK) @(posedge clk);
    end
    rx_frame <= cap;
    rx_count <= rx_count + 8'h01;
  end
endmodule : asp_peer_model

// ==== verification/async_serial_port_core_bench.sv ====
// Register-level bench for the serial port core with a line peer
`timescale 1ns/10ps
`include "asp_regs.svh"
module async_serial_port_core_bench
  import asp_pkg::*;
;
  localparam int TICK = 16;
  localparam int BIT = 256;
  logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, serial_in_pin, serial_out_pin, irq, er;
  logic send = 0, m_c8 = 0, m_bp = 0, m_bs = 0, m_busy, c8, s2;
  logic [1:0] m_par = '0, p;
  logic [7:0] m_byte = '0, rx_count, c0;
  logic [11:0] rx_frame;
  logic [7:0] txb [4] = '{8'h96, 8'h35, 8'hc1, 8'h7e};
  logic [7:0] rxb [4] = '{8'h4b, 8'hf0, 8'h29, 8'hd3};
  int fail_count = 0, check_count = 0, i, n, len;

  always #50 clk = ~clk;

  asp_core uut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_in_pin(serial_in_pin),
    .serial_out_pin(serial_out_pin), .irq(irq));
  asp_peer_model #(.BIT_CLK(BIT)) mdl (.clk(clk), .line_in(serial_out_pin), .line_out(serial_in_pin),
    .send(send), .send_byte(m_byte), .char8(m_c8), .par_mode(m_par), .bad_par(m_bp), .bad_stop(m_bs),
    .rx_frame(rx_frame), .rx_count(rx_count), .busy(m_busy));

  task end_of_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask : chk

  // One APB transfer, held until pready, then one idle cycle
  // Answer taken mid-cycle, before the edge that may clear on read
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int w;
    logic rdy;
    w = 0;
    rdy = 1'b0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    while (rdy !== 1'b1 && w < 50) begin
      @(negedge clk);
      rdy = pready;
      rd = prdata;
      er = pslverr;
      w++;
      @(posedge clk);
    end
    if (rdy !== 1'b1) chk("apb ready", 1, 0);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
    chk("slave error", 0, er);
  endtask : rdc

  function automatic logic [31:0] mode(input logic [1:0] pm, input logic c, s, te, re);
    return {24'h0, 1'b1, te, re, pm, c, s, 1'b1};
  endfunction : mode

  function automatic logic [11:0] exp_frame(input logic [7:0] b, input logic c, input logic [1:0] pm);
    logic [11:0] f;
    logic [7:0] d;
    int nb;
    f = '1;
    f[0] = 1'b0;
    d = c ? b : {1'b0, b[6:0]};
    nb = c ? 8 : 7;
    for (int k = 0; k < nb; k++) f[1 + k] = d[k];
    if (pm != 2'd0) f[1 + nb] = (pm == 2'd2) ? ~^d : (pm == 2'd3) ? ^d : 1'b0;
    return f;
  endfunction : exp_frame

  // power first, enables, wait base ticks
  task start_port(input logic [1:0] pm, input logic c, s, te, re);
    apb(1'b1, `ASP_OFF_MODE, mode(pm, c, s, 1'b0, 1'b0));
    apb(1'b1, `ASP_OFF_MODE, mode(pm, c, s, te, re));
    repeat (4 * TICK) @(posedge clk);
  endtask : start_port

  task peer_send(input logic [7:0] b, input logic c, input logic [1:0] pm, input logic bp, bs);
    while (m_busy === 1'b1) @(posedge clk);
    m_byte <= b;
    m_c8 <= c;
    m_par <= pm;
    m_bp <= bp;
    m_bs <= bs;
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
  endtask : peer_send

  task poll_stat(input int b);
    n = 0;
    apb(1'b0, `ASP_OFF_IRQ_STAT, 32'h0);
    while (rd[b] !== 1'b1 && n < 2000) begin
      n++;
      apb(1'b0, `ASP_OFF_IRQ_STAT, 32'h0);
    end
    chk("irq status event", 1, rd[b]);
  endtask : poll_stat

  // Watchdog against a hung wait
  initial begin
    repeat (90000) @(posedge clk);
    fail_count++;
    end_of_test;
  end

  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rdc("mode reset", `ASP_OFF_MODE, 32'h01);
    rdc("divider reset", `ASP_OFF_BAUD, 32'h10);
    rdc("rx buffer reset", `ASP_OFF_RXDATA, 32'hff);
    rdc("error reset", `ASP_OFF_STATUS, 32'h0);
    apb(1'b1, 12'h01c, 32'hffffffff);
    rdc("unmapped", 12'h01c, 32'h0);
    apb(1'b1, `ASP_OFF_BAUD, 32'hffffffff);
    rdc("divider width", `ASP_OFF_BAUD, 32'h1f);
    apb(1'b1, `ASP_OFF_BAUD, 32'h10);
    chk("line idle", 1, serial_out_pin);
    $display("test reset done");
    // every parity mode, both directions at once
    for (i = 0; i < 4; i++) begin
      p = i[1:0];
      c8 = ~i[0];
      s2 = i[1];
      len = 2 + (c8 ? 8 : 7) + (p != 2'd0) + s2;
      apb(1'b1, `ASP_OFF_IRQ_MASK, 32'h1);
      start_port(p, c8, s2, 1'b1, 1'b1);
      c0 = rx_count;
      peer_send(rxb[i], c8, p, i == 1, 1'b0);
      apb(1'b1, `ASP_OFF_TXDATA, {24'h0, txb[i]});
      n = 0;
      while (serial_out_pin !== 1'b0 && n < 2000) begin
        n++;
        @(posedge clk);
      end
      n = 0;
      while (irq !== 1'b1 && n < 4000) begin
        n++;
        @(posedge clk);
      end
      chk("tx frame cycles", 1, n > len * BIT - 16 && n < len * BIT + 32);
      n = 0;
      while (rx_count === c0 && n < 4000) begin
        n++;
        @(posedge clk);
      end
      chk("tx frame bits", exp_frame(txb[i], c8, p), rx_frame);
      poll_stat(`ASP_IRQ_RXDONE);
      rdc("rx data", `ASP_OFF_RXDATA, c8 ? rxb[i] : rxb[i] & 8'h7f);
      rdc("rx status", `ASP_OFF_STATUS, 32'h0);
      apb(1'b1, `ASP_OFF_IRQ_STAT, 32'h7);
      chk("irq after clear", 0, irq);
      rdc("irq status clear", `ASP_OFF_IRQ_STAT, 32'h0);
      apb(1'b1, `ASP_OFF_MODE, mode(p, c8, s2, 1'b0, 1'b0));
      repeat (3 * TICK) @(posedge clk);
      $display("test mode %0d done", i);
    end
    apb(1'b1, `ASP_OFF_IRQ_MASK, 32'h0);
    start_port(2'd2, 1'b1, 1'b0, 1'b0, 1'b1);
    for (i = 0; i < 2; i++) begin
      peer_send(8'h6d, 1'b1, 2'd2, i == 0, i == 1);
      poll_stat(`ASP_IRQ_RXERR);
      apb(1'b1, `ASP_OFF_IRQ_STAT, 32'h7);
      rdc("error kind", `ASP_OFF_STATUS, (i == 0) ? 32'h4 : 32'h2);
      rdc("error cleared", `ASP_OFF_STATUS, 32'h0);
      apb(1'b0, `ASP_OFF_RXDATA, 32'h0);
    end
    // Low stop bit may start a false frame; let it finish and drain it
    repeat (12 * BIT) @(posedge clk);
    apb(1'b0, `ASP_OFF_STATUS, 32'h0);
    apb(1'b0, `ASP_OFF_RXDATA, 32'h0);
    apb(1'b1, `ASP_OFF_IRQ_STAT, 32'h7);
    $display("test errors done");
    peer_send(8'h3c, 1'b1, 2'd2, 1'b0, 1'b0);
    poll_stat(`ASP_IRQ_RXDONE);
    apb(1'b1, `ASP_OFF_IRQ_STAT, 32'h7);
    peer_send(8'hc3, 1'b1, 2'd2, 1'b0, 1'b0);
    poll_stat(`ASP_IRQ_RXERR);
    chk("masked irq", 0, irq);
    rdc("overrun flag", `ASP_OFF_STATUS, 32'h1);
    rdc("kept data", `ASP_OFF_RXDATA, 32'h3c);
    apb(1'b1, `ASP_OFF_IRQ_MASK, 32'h4);
    chk("unmasked irq", 1, irq);
    apb(1'b1, `ASP_OFF_IRQ_STAT, 32'h4);
    chk("irq cleared", 0, irq);
    $display("test overrun done");
    // power off resets buffer and errors
    peer_send(8'h81, 1'b1, 2'd2, 1'b1, 1'b0);
    poll_stat(`ASP_IRQ_RXERR);
    apb(1'b1, `ASP_OFF_MODE, 32'h01);
    rdc("buffer after off", `ASP_OFF_RXDATA, 32'hff);
    rdc("errors after off", `ASP_OFF_STATUS, 32'h0);
    chk("line after off", 1, serial_out_pin);
    $display("test power off done");
    end_of_test;
  end
endmodule : async_serial_port_core_bench
